// [hw/eeprom_regs.svh]
/*
 Named constants for the serial array slave and its bus master: timing,
 array geometry and slave address byte layout.
 Assumes a 10 MHz reference clock shared by both ends.
*/
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

`define EE_CLK_PERIOD_NS 100
`define EE_TWC_NS 5000000
`define EE_TWC_CYCLES (`EE_TWC_NS / `EE_CLK_PERIOD_NS)
`define EE_BIT_TIME_NS 10000
`define EE_QDIV_CYCLES (`EE_BIT_TIME_NS / 4 / `EE_CLK_PERIOD_NS)
`define EE_QDIV_MIN 8
`define EE_ADDR_BITS 14
`define EE_PAGE_BYTES 64
`define EE_DEV_TYPE 4'h5
`define EE_SLV_TYPE_MSB 7
`define EE_SLV_TYPE_LSB 4
`define EE_SLV_ZERO_BIT 3
`define EE_SLV_SEL_HI 2
`define EE_SLV_SEL_LO 1
`define EE_SLV_RW_BIT 0
`define EE_ADDR_HI_BITS 6
`define EE_LAST_BIT 4'h7
`define EE_BYTE_BITS 4'h8

`endif

// [hw/eeprom_pkg.sv]
/*
 Types shared by the slave and master ends of the two-wire link.
 Assumes nothing beyond the constants header.
*/
package eeprom_pkg;

	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_DEV = 7'b0000010,
		S_AHI = 7'b0000100,
		S_ALO = 7'b0001000,
		S_WD = 7'b0010000,
		S_ACK = 7'b0100000,
		S_RD = 7'b1000000
	} dev_state_t;

	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ = 2'h2,
		OP_STOP = 2'h3
	} host_op_t;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_BIT = 4'b0100,
		H_STOP = 4'b1000
	} host_state_t;

endpackage

// [hw/eeprom_link_if.sv]
/*
 Two-wire link between the bus master and the array slave.
 Assumes open-drain SDA: a party pulls low when its enable is low and
 its data is low; SCL is driven by the master alone.
*/
`timescale 1ns/10ps
`default_nettype none

interface eeprom_link_if;
	logic scl_m;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	logic scl;
	logic sda;

	assign scl = scl_m;
	assign sda = !((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o));

	modport device (input scl, input sda, output sda_s_o, output sda_s_oe_n);
	modport host (output scl_m, output sda_m_o, output sda_m_oe_n, input sda);
endinterface

`default_nettype wire

// [hw/serial_eeprom_access_slave.sv]
/*
 Array slave end of the two-wire link: slave address decode, word
 address load, page writes through a page buffer, self-timed commit and
 sequential reads from a 16K-byte array.
 Assumes SCL and SDA arrive asynchronously; write enable latch, protected
 address indication and reset-active inhibit come from logic on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"

module serial_eeprom_access_slave #(
	parameter int TWC_CYCLES = `EE_TWC_CYCLES,
	parameter int ADDR_BITS = `EE_ADDR_BITS,
	parameter int PAGE_BYTES = `EE_PAGE_BYTES,
	parameter logic [3:0] DEV_TYPE = `EE_DEV_TYPE // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic rst,
	eeprom_link_if.device link,
	input wire logic chip_select_hi,
	input wire logic chip_select_lo,
	input wire logic write_enable_latch,
	input wire logic addr_protected,
	input wire logic reset_active,
	output logic [ADDR_BITS-1:0] word_addr,
	output logic write_busy
);
	localparam int PW = $clog2(PAGE_BYTES);
	localparam int CW = $clog2(TWC_CYCLES + 1);

	generate
		if (PAGE_BYTES != (1 << PW) || TWC_CYCLES <= PAGE_BYTES || ADDR_BITS <= PW) begin : g_bad
			$error("serial_eeprom_access_slave: unsupported geometry or write time");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and bus conditions

	logic [1:0] scl_sy;
	logic [1:0] sda_sy;
	logic [1:0] csh_sy;
	logic [1:0] csl_sy;
	logic scl_p;
	logic sda_p;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			csh_sy <= 2'h0;
			csl_sy <= 2'h0;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_sy <= {scl_sy[0], link.scl};
			sda_sy <= {sda_sy[0], link.sda};
			csh_sy <= {csh_sy[0], chip_select_hi};
			csl_sy <= {csl_sy[0], chip_select_lo};
			scl_p <= scl_sy[1];
			sda_p <= sda_sy[1];
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise = scl_sy[1] && !scl_p;
	assign scl_fall = !scl_sy[1] && scl_p;
	assign bus_start = scl_sy[1] && scl_p && sda_p && !sda_sy[1];
	assign bus_stop = scl_sy[1] && scl_p && !sda_p && sda_sy[1];

	////////////////////////////////////////////////////////////////////////
	// Byte reception events

	eeprom_pkg::dev_state_t state_q;
	eeprom_pkg::dev_state_t nxt_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] rd_q;
	logic ack_q;
	logic ack_ph_q;
	logic rack_ok_q;
	logic data_seen_q;
	logic busy_q;
	logic sda_oe_n_q;
	logic [CW-1:0] wc_cnt_q;
	logic [PAGE_BYTES-1:0] mask_q;

	logic receiving;
	logic rx_last;
	logic [7:0] new_byte;
	logic slv_match;
	logic wd_store;
	logic rd_load;
	logic commit;
	logic wc_done;

	assign receiving = (state_q == eeprom_pkg::S_DEV) || (state_q == eeprom_pkg::S_AHI) ||
		(state_q == eeprom_pkg::S_ALO) || (state_q == eeprom_pkg::S_WD);
	assign rx_last = receiving && scl_rise && (bit_cnt_q == `EE_LAST_BIT) && !reset_active;
	assign new_byte = {shift_q[6:0], sda_sy[1]};
	// All bits but R/W compared, zero bit included
	assign slv_match = (new_byte[`EE_SLV_TYPE_MSB:`EE_SLV_TYPE_LSB] == DEV_TYPE) &&
		!new_byte[`EE_SLV_ZERO_BIT] && (new_byte[`EE_SLV_SEL_HI] == csh_sy[1]) &&
		(new_byte[`EE_SLV_SEL_LO] == csl_sy[1]);
	assign wd_store = rx_last && (state_q == eeprom_pkg::S_WD) && !addr_protected;
	assign rd_load = (rx_last && (state_q == eeprom_pkg::S_DEV) && slv_match &&
		new_byte[`EE_SLV_RW_BIT]) || (!ack_ph_q && (state_q == eeprom_pkg::S_ACK) &&
		(nxt_q == eeprom_pkg::S_RD) && rack_ok_q && scl_rise && !sda_sy[1]);
	// Stop only counts once a whole byte and its acknowledge have passed
	assign commit = bus_stop && !reset_active && (state_q == eeprom_pkg::S_WD) &&
		(bit_cnt_q <= 4'h1) && data_seen_q && write_enable_latch && (mask_q != '0);
	assign wc_done = busy_q && (wc_cnt_q == CW'(TWC_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////
	// Protocol state machine

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= eeprom_pkg::S_IDLE;
			nxt_q <= eeprom_pkg::S_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ack_q <= 1'b0;
			ack_ph_q <= 1'b0;
			rack_ok_q <= 1'b0;
			data_seen_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (reset_active || busy_q) begin
			// While writing nothing on the bus is seen, so polls go unanswered
			state_q <= eeprom_pkg::S_IDLE;
			ack_ph_q <= 1'b0;
			data_seen_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (bus_start) begin
			state_q <= eeprom_pkg::S_DEV;
			bit_cnt_q <= 4'h0;
			ack_ph_q <= 1'b0;
			data_seen_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (bus_stop) begin
			// Stop after the word address leaves just the counter loaded
			state_q <= eeprom_pkg::S_IDLE;
			sda_oe_n_q <= 1'b1;
		end else begin
			case (state_q)
				eeprom_pkg::S_DEV, eeprom_pkg::S_AHI, eeprom_pkg::S_ALO, eeprom_pkg::S_WD: begin
					if (scl_rise) begin
						shift_q <= new_byte;
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					if (rx_last) begin
						state_q <= eeprom_pkg::S_ACK;
						bit_cnt_q <= 4'h0;
						ack_q <= 1'b1;
						rack_ok_q <= 1'b0;
						case (state_q)
							eeprom_pkg::S_DEV: begin
								ack_q <= slv_match;
								nxt_q <= new_byte[`EE_SLV_RW_BIT] ? eeprom_pkg::S_RD : eeprom_pkg::S_AHI;
							end
							eeprom_pkg::S_AHI: nxt_q <= eeprom_pkg::S_ALO;
							eeprom_pkg::S_ALO: nxt_q <= eeprom_pkg::S_WD;
							default: begin
								ack_q <= !addr_protected;
								nxt_q <= eeprom_pkg::S_WD;
								data_seen_q <= data_seen_q || !addr_protected;
							end
						endcase
					end
				end
				eeprom_pkg::S_ACK: begin
					if (scl_fall && !ack_ph_q) begin
						ack_ph_q <= 1'b1;
						sda_oe_n_q <= !ack_q;
					end else if (scl_fall) begin
						ack_ph_q <= 1'b0;
						bit_cnt_q <= 4'h0;
						state_q <= ack_q ? nxt_q : eeprom_pkg::S_IDLE;
						sda_oe_n_q <= 1'b1;
						if (ack_q && nxt_q == eeprom_pkg::S_RD) begin
							sda_oe_n_q <= rd_q[7];
							tx_q <= {rd_q[6:0], 1'b1};
						end
					end
				end
				eeprom_pkg::S_RD: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					if (scl_fall && bit_cnt_q == `EE_BYTE_BITS) begin
						// Master acknowledge slot reuses the ack state, slave silent
						state_q <= eeprom_pkg::S_ACK;
						nxt_q <= eeprom_pkg::S_RD;
						ack_q <= 1'b0;
						ack_ph_q <= 1'b0;
						rack_ok_q <= 1'b1;
						sda_oe_n_q <= 1'b1;
					end else if (scl_fall) begin
						sda_oe_n_q <= tx_q[7];
						tx_q <= {tx_q[6:0], 1'b1};
					end
				end
				default: state_q <= eeprom_pkg::S_IDLE;
			endcase
			// Master acknowledge keeps the stream going, nack ends it
			if (state_q == eeprom_pkg::S_ACK && rack_ok_q && !ack_ph_q && scl_rise) begin
				ack_q <= !sda_sy[1];
				ack_ph_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address counter

	logic [ADDR_BITS-1:0] addr_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			addr_q <= '0; // Zero until the first word address load or read
		end else if (rx_last && state_q == eeprom_pkg::S_AHI) begin
			addr_q[ADDR_BITS-1:8] <= new_byte[ADDR_BITS-9:0];
		end else if (rx_last && state_q == eeprom_pkg::S_ALO) begin
			addr_q[7:0] <= new_byte;
		end else if (wd_store) begin
			addr_q[PW-1:0] <= addr_q[PW-1:0] + PW'(1);
		end else if (rd_load) begin
			addr_q <= addr_q + ADDR_BITS'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Page buffer; a later byte to the same slot simply replaces it

	logic [7:0] page_buf [PAGE_BYTES];
	logic [ADDR_BITS-PW-1:0] page_q;

	always_ff @(posedge ref_clk) begin
		if (wd_store) begin
			page_buf[addr_q[PW-1:0]] <= new_byte;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_q <= '0;
			page_q <= '0;
		end else if (wd_store) begin
			mask_q[addr_q[PW-1:0]] <= 1'b1;
			page_q <= addr_q[ADDR_BITS-1:PW];
		end else if (wc_done || reset_active || (bus_start && !busy_q) || (bus_stop && !commit && !busy_q)) begin
			mask_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Self-timed write cycle; commit walks the page one slot per cycle

	logic [7:0] mem [2**ADDR_BITS];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			wc_cnt_q <= '0;
		end else if (commit && !busy_q) begin
			busy_q <= 1'b1;
			wc_cnt_q <= '0;
		end else if (busy_q) begin
			busy_q <= !wc_done;
			wc_cnt_q <= wc_cnt_q + CW'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (busy_q && wc_cnt_q < CW'(PAGE_BYTES) && mask_q[wc_cnt_q[PW-1:0]]) begin
			mem[{page_q, wc_cnt_q[PW-1:0]}] <= page_buf[wc_cnt_q[PW-1:0]];
		end
		if (rd_load) begin
			rd_q <= mem[addr_q];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	logic sda_o_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0; // Open drain: only ever pulls low
		end
	end

	assign link.sda_s_o = sda_o_q;
	assign link.sda_s_oe_n = sda_oe_n_q;
	assign word_addr = addr_q;
	assign write_busy = busy_q;
endmodule

`default_nettype wire

// [hw/serial_eeprom_bus_master.sv]
/*
 Master end of the two-wire link: executes start, byte write, byte read
 and stop commands, deriving SCL from ref_clk by a quarter-bit divider.
 Assumes the user sequences commands per the slave protocol.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"

module serial_eeprom_bus_master #(
	parameter int QDIV = `EE_QDIV_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	eeprom_link_if.host link,
	input wire logic cmd_valid,
	input wire eeprom_pkg::host_op_t cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack_n,
	output logic cmd_ready,
	output logic done,
	output logic [7:0] rx_byte,
	output logic ack_seen
);
	localparam int DW = $clog2(QDIV);

	generate
		if (QDIV < `EE_QDIV_MIN) begin : g_bad
			$error("serial_eeprom_bus_master: QDIV too small for slave synchronisers");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Quarter-bit enable and SDA synchroniser

	logic [DW-1:0] div_q;
	logic tick;
	logic [1:0] sda_sy;
	assign tick = (div_q == DW'(QDIV - 1));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_q <= '0;
			sda_sy <= 2'h3;
		end else begin
			div_q <= tick ? '0 : div_q + DW'(1);
			sda_sy <= {sda_sy[0], link.sda};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command sequencer

	eeprom_pkg::host_state_t state_q;
	logic [1:0] ph_q;
	logic [3:0] bits_q;
	logic [8:0] sh_q;
	logic [8:0] rx_q;
	logic scl_q;
	logic sda_oe_n_q;
	logic ready_q;
	logic done_q;
	logic [7:0] rx_byte_q;
	logic ack_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= eeprom_pkg::H_IDLE;
			ph_q <= 2'h0;
			bits_q <= 4'h0;
			sh_q <= '1;
			rx_q <= '0;
			scl_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			ready_q <= 1'b1;
			done_q <= 1'b0;
			rx_byte_q <= 8'h00;
			ack_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				eeprom_pkg::H_IDLE: begin
					if (cmd_valid && ready_q) begin
						ready_q <= 1'b0;
						ph_q <= 2'h0;
						bits_q <= 4'h0;
						case (cmd_op)
							eeprom_pkg::OP_START: state_q <= eeprom_pkg::H_START;
							eeprom_pkg::OP_STOP: state_q <= eeprom_pkg::H_STOP;
							eeprom_pkg::OP_WRITE: begin
								state_q <= eeprom_pkg::H_BIT;
								sh_q <= {cmd_data, 1'b1};
							end
							default: begin
								state_q <= eeprom_pkg::H_BIT;
								sh_q <= {8'hff, cmd_ack_n};
							end
						endcase
					end
				end
				eeprom_pkg::H_START, eeprom_pkg::H_STOP: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: sda_oe_n_q <= (state_q == eeprom_pkg::H_STOP) ? 1'b0 : 1'b1;
							2'h1: scl_q <= 1'b1;
							2'h2: sda_oe_n_q <= (state_q == eeprom_pkg::H_STOP) ? 1'b1 : 1'b0;
							default: begin
								scl_q <= (state_q == eeprom_pkg::H_STOP);
								state_q <= eeprom_pkg::H_IDLE;
								ready_q <= 1'b1;
								done_q <= 1'b1;
							end
						endcase
					end
				end
				eeprom_pkg::H_BIT: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: sda_oe_n_q <= sh_q[8];
							2'h1: scl_q <= 1'b1;
							2'h2: rx_q <= {rx_q[7:0], sda_sy[1]};
							default: begin
								scl_q <= 1'b0;
								sh_q <= {sh_q[7:0], 1'b1};
								bits_q <= bits_q + 4'h1;
								if (bits_q == `EE_BYTE_BITS) begin
									// Slot nine carries the acknowledge
									sda_oe_n_q <= 1'b1;
									state_q <= eeprom_pkg::H_IDLE;
									ready_q <= 1'b1;
									done_q <= 1'b1;
									rx_byte_q <= rx_q[8:1];
									ack_q <= !rx_q[0];
								end
							end
						endcase
					end
				end
				default: state_q <= eeprom_pkg::H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	logic sda_o_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0; // Open drain: only ever pulls low
		end
	end

	assign link.scl_m = scl_q;
	assign link.sda_m_o = sda_o_q;
	assign link.sda_m_oe_n = sda_oe_n_q;
	assign cmd_ready = ready_q;
	assign done = done_q;
	assign rx_byte = rx_byte_q;
	assign ack_seen = ack_q;
endmodule

`default_nettype wire

// [tb/serial_eeprom_link_chk.sv]
/*
 Protocol watcher on the two-wire link between the bus master and the array slave.
 Assumes one ref_clk domain and SCL/SDA as resolved by the link interface.
*/
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom_link_chk #(
	parameter int QDIV = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_m,
	input wire logic sda_m_o,
	input wire logic sda_m_oe_n,
	input wire logic sda_s_o,
	input wire logic sda_s_oe_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic write_busy
);
	logic scl_q, sda_q, busy_q, rise_busy_q, start_w, stop_w;
	logic [7:0] fall_cnt_q, high_cnt_q;

	assign start_w = scl_q && scl && sda_q && !sda;
	assign stop_w = scl_q && scl && !sda_q && sda;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			busy_q <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			busy_q <= start_w || (busy_q && !stop_w);
		end
	end

	// Falls since the last start; the start itself adds one
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fall_cnt_q <= 8'h00;
		end else if (start_w) begin
			fall_cnt_q <= 8'h00;
		end else if (scl_q && !scl && fall_cnt_q != 8'hff) begin
			fall_cnt_q <= fall_cnt_q + 8'h01;
		end
	end

	// Only highs begun inside a frame have a fixed length
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			high_cnt_q <= 8'h00;
			rise_busy_q <= 1'b0;
		end else if (scl && !scl_q) begin
			high_cnt_q <= 8'h01;
			rise_busy_q <= busy_q;
		end else begin
			high_cnt_q <= (scl && high_cnt_q != 8'hff) ? high_cnt_q + 8'h01 : high_cnt_q;
			rise_busy_q <= rise_busy_q && !stop_w;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_reset_release: assert property ($fell(rst) |-> sda_s_oe_n && sda_m_oe_n && scl_m)
		else $error("link not idle after reset");
	a_idle_released: assert property (!busy_q |-> sda_s_oe_n)
		else $error("slave drives SDA outside a frame");
	a_no_early_ack: assert property (busy_q && fall_cnt_q < 8'h09 |-> sda_s_oe_n)
		else $error("slave drives before slave byte complete");
	a_stable_high: assert property (scl && scl_q |-> $stable(sda_s_oe_n))
		else $error("slave SDA changed while SCL high");
	a_open_drain: assert property (!sda_s_o && !sda_m_o)
		else $error("SDA data not tied low");
	a_busy_quiet: assert property (write_busy |-> sda_s_oe_n)
		else $error("slave drives SDA during write cycle");
	a_idle_clock: assert property (!busy_q |-> scl_m)
		else $error("SCL low outside a frame");
	a_high_time: assert property (scl_q && !scl && rise_busy_q |-> high_cnt_q inside {[2*QDIV-1:2*QDIV+1]})
		else $error("SCL high time wrong");
	a_ack_release: assert property ($fell(sda_s_oe_n) && fall_cnt_q == 8'h12 |-> !sda_s_oe_n [*8] ##[20:28] sda_s_oe_n)
		else $error("word address ack not one slot");

	c_addr_ack: cover property (fall_cnt_q == 8'h09 && !sda_s_oe_n);
	c_restart: cover property (start_w && busy_q);
	c_read_data: cover property (!sda_s_oe_n && fall_cnt_q > 8'h13);
	c_busy_poll: cover property (write_busy && start_w);
endmodule

`default_nettype wire

// [tb/serial_eeprom_access_slave_test.sv]
/*
 Self-checking bench: bus master and array slave joined by the link interface.
 Assumes 10 MHz ref_clk, a shortened write cycle and the minimum quarter divider.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"

module serial_eeprom_access_slave_test;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	eeprom_pkg::host_op_t cmd_op = eeprom_pkg::OP_START;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_ack_n = 1'b1;
	logic chip_select_hi = 1'b0;
	logic chip_select_lo = 1'b0;
	logic write_enable_latch = 1'b1;
	logic prot = 1'b0;
	logic reset_active = 1'b0;
	logic addr_protected, cmd_ready, done, ack_seen, write_busy;
	logic [7:0] rx_byte;
	logic [13:0] word_addr;
	logic [7:0] mdl [int];
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;

	// Upper quarter of the array is protected while prot is set
	assign addr_protected = prot && word_addr[13:12] == 2'h3;

	eeprom_link_if link ();
	serial_eeprom_access_slave #(.TWC_CYCLES(1000)) serial_eeprom_access_slave_i (.ref_clk(ref_clk), .rst(rst),
		.link(link), .chip_select_hi(chip_select_hi), .chip_select_lo(chip_select_lo),
		.write_enable_latch(write_enable_latch), .addr_protected(addr_protected), .reset_active(reset_active),
		.word_addr(word_addr), .write_busy(write_busy));
	serial_eeprom_bus_master #(.QDIV(8)) serial_eeprom_bus_master_i (.ref_clk(ref_clk), .rst(rst), .link(link),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack_n(cmd_ack_n),
		.cmd_ready(cmd_ready), .done(done), .rx_byte(rx_byte), .ack_seen(ack_seen));
	serial_eeprom_link_chk #(.QDIV(8)) serial_eeprom_link_chk_i (.ref_clk(ref_clk), .rst(rst), .scl_m(link.scl_m),
		.sda_m_o(link.sda_m_o), .sda_m_oe_n(link.sda_m_oe_n), .sda_s_o(link.sda_s_o),
		.sda_s_oe_n(link.sda_s_oe_n), .scl(link.scl), .sda(link.sda), .write_busy(write_busy));

	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [7:0] sb(input logic rw);
		return {`EE_DEV_TYPE, 1'b0, chip_select_hi, chip_select_lo, rw};
	endfunction

	// Held until taken, then waits for done under a bound
	task automatic cmd(input eeprom_pkg::host_op_t op, input logic [7:0] d, input logic an);
		int n;
		n = 0;
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		cmd_ack_n = an;
		@(posedge ref_clk);
		while (cmd_ready !== 1'b1) @(posedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask

	task automatic bus_start;
		cmd(eeprom_pkg::OP_START, 8'h00, 1'b1);
	endtask

	task automatic bus_stop;
		cmd(eeprom_pkg::OP_STOP, 8'h00, 1'b1);
	endtask

	task automatic wb(input logic [7:0] d, input logic exp);
		cmd(eeprom_pkg::OP_WRITE, d, 1'b1);
		chk("ack", ack_seen, exp);
	endtask

	// Upper bits of the high byte are random: the slave must drop them
	task automatic seta(input logic [13:0] a);
		bus_start();
		wb(sb(1'b0), 1'b1);
		wb({2'($urandom), a[13:8]}, 1'b1);
		wb(a[7:0], 1'b1);
	endtask

	task automatic rdn(input logic [13:0] a, input int n);
		bus_start();
		wb(sb(1'b1), 1'b1);
		for (int i = 0; i < n; i++) begin
			cmd(eeprom_pkg::OP_READ, 8'h00, i == n - 1);
			if (mdl.exists(a))
				chk("data", rx_byte, mdl[a]);
			a++;
		end
		bus_stop();
		chk("addr", word_addr, a);
	endtask

	task automatic commit(input logic busy);
		int n;
		n = 0;
		bus_stop();
		repeat (10) @(posedge ref_clk);
		#1;
		chk("busy", write_busy, busy);
		do begin
			bus_start();
			cmd(eeprom_pkg::OP_WRITE, sb(1'b0), 1'b1);
			bus_stop();
			n++;
		end while (ack_seen !== 1'b1 && n < 20);
		chk("poll", n > 1, busy);
		chk("ready", ack_seen, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [13:0] a;
		logic [7:0] d;
		int n;
		void'($urandom(32'h48e37d8d));
		@(negedge ref_clk);
		chip_select_hi = 1'($urandom);
		chip_select_lo = 1'($urandom);
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		chk("reset", {word_addr, write_busy, cmd_ready}, 16'h0001);
		for (int t = 0; t < 3; t++) begin
			a = t == 0 ? 14'h003c : t == 1 ? 14'h3fc0 : {2'h1, 12'($urandom)};
			n = t == 0 ? 12 : t == 1 ? 66 : 1;
			seta(a);
			for (int i = 0; i < n; i++) begin
				d = 8'($urandom);
				wb(d, 1'b1);
				mdl[{a[13:6], a[5:0] + 6'(i)}] = d;
			end
			commit(1'b1);
			chk("addr", word_addr, {a[13:6], a[5:0] + 6'(n)});
		end
		seta(14'h3ffe);
		rdn(14'h3ffe, 4);
		rdn(14'h0002, 1);
		seta(a);
		bus_stop();
		repeat (10) @(posedge ref_clk);
		#1;
		chk("idle", {word_addr, write_busy}, {a, 1'b0});
		rdn(a, 2);
		@(negedge ref_clk);
		write_enable_latch = 1'b0;
		seta(a);
		wb(~mdl[a], 1'b1);
		commit(1'b0);
		@(negedge ref_clk);
		write_enable_latch = 1'b1;
		// Refused write still stepped the in-page counter, so wrap within the page
		rdn({a[13:6], a[5:0] + 6'h01}, 1);
		seta(a);
		rdn(a, 1);
		@(negedge ref_clk);
		prot = 1'b1;
		seta(14'h3fc5);
		wb(8'h5a, 1'b0);
		commit(1'b0);
		@(negedge ref_clk);
		prot = 1'b0;
		seta(14'h3fc5);
		rdn(14'h3fc5, 1);
		for (int b = 1; b < 8; b++) begin
			bus_start();
			wb(sb(1'b0) ^ (8'h01 << b), 1'b0);
			bus_stop();
		end
		@(negedge ref_clk);
		reset_active = 1'b1;
		bus_start();
		wb(sb(1'b1), 1'b0);
		bus_stop();
		@(negedge ref_clk);
		reset_active = 1'b0;
		rdn(14'h3fc6, 1);
		wrap_up();
	end
endmodule

`default_nettype wire
